// ### bench/mhu_cp_model.sv
// Register file model of the system coprocessor beside the unit
`timescale 1ns/1ps
module mhu_cp_model (
    input  wire logic        clk_sys_i,
    input  wire logic [4:0]  rd_addr_i,
    input  wire logic        wr_en_i,
    input  wire logic [4:0]  wr_addr_i,
    input  wire logic [63:0] wr_data_i,
    output logic      [31:0] rd_data_o
);
    logic [31:0] regs [32];
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = {16'hc0de, 11'h0, i[4:0]};
        end
    end
    // Combinational: the unit samples data in its fetch cycle
    assign rd_data_o = regs[rd_addr_i];
    // Only the low word is kept; no translation state to disturb
    always @(posedge clk_sys_i) begin
        if (wr_en_i === 1'b1) begin
            regs[wr_addr_i] <= wr_data_i[31:0];
        end
    end
endmodule

// ### bench/multiply_accumulate_hilo_unit_test.sv
// Self-checking bench for the product register unit
`timescale 1ns/1ps
module multiply_accumulate_hilo_unit_test
    import mhu_pkg::*;
;
    localparam logic [5:0] FN_RD_UP = 6'h10;
    logic        clk_sys_i, rstn_i, instr_valid_i, mode64_i, user_or_super_i, coproc_usable_i;
    logic        dword_mul_issue_i, word_div_issue_i, dword_div_issue_i, stall_o, wb_valid_o;
    logic        coproc_wr_en_o, coproc_unusable_o, upper_defined_o, bottom_defined_o;
    logic [31:0] instr_i, coproc_rd_data_i;
    logic [63:0] rs_val_i, rt_val_i, wb_data_o, coproc_wr_data_o, hi, lo, v, t;
    logic [4:0]  wb_idx_o, coproc_rd_addr_o, coproc_wr_addr_o;
    logic signed [63:0] p;
    logic [68:0] exp_q[$];
    logic [68:0] e;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          st;
    integer      seed = 32'h9dfffd28;
    int          gaps[3] = '{4, 36, 68};

    mhu_unit #(.FN_READ_UPPER(FN_RD_UP)) u_dut (
        .clk_sys_i, .rstn_i, .instr_valid_i, .instr_i, .rs_val_i, .rt_val_i, .mode64_i,
        .user_or_super_i, .coproc_usable_i, .dword_mul_issue_i, .word_div_issue_i,
        .dword_div_issue_i, .coproc_rd_data_i, .stall_o, .wb_valid_o, .wb_idx_o, .wb_data_o,
        .coproc_rd_addr_o, .coproc_wr_en_o, .coproc_wr_addr_o, .coproc_wr_data_o,
        .coproc_unusable_o, .upper_defined_o, .bottom_defined_o
    );
    mhu_cp_model u_cp (
        .clk_sys_i, .rd_addr_i(coproc_rd_addr_o), .wr_en_i(coproc_wr_en_o),
        .wr_addr_i(coproc_wr_addr_o), .wr_data_i(coproc_wr_data_o), .rd_data_o(coproc_rd_data_i)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [68:0] seen, input logic [68:0] want);
        n_tests++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask

    function automatic logic [63:0] ext(input logic [31:0] w);
        ext = mode64_i ? {{32{w[31]}}, w} : {32'h0, w};
    endfunction
    function automatic logic [31:0] sp(input logic [5:0] fn, input logic [4:0] rd);
        sp = {OPC_SPECIAL, 10'h0, rd, 5'h0, fn};
    endfunction
    function automatic logic [31:0] cp(input logic [4:0] sub, rt, rd);
        cp = {OPC_SYS_COPROC, sub, rt, rd, 11'h0};
    endfunction

    // Holds the request until an edge with no stall; counts stalled cycles
    task automatic issue(input logic [31:0] ins, input logic [63:0] x, y);
        instr_valid_i = 1'b1;
        instr_i = ins;
        rs_val_i = x;
        rt_val_i = y;
        st = 0;
        @(negedge clk_sys_i);
        while (stall_o !== 1'b0 && st < 100) begin
            st++;
            @(negedge clk_sys_i);
        end
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic nop(input int n);
        instr_valid_i = 1'b0;
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic rd_prod(input logic up, input logic [4:0] idx);
        exp_q.push_back({idx, up ? hi : lo});
        issue(sp(up ? FN_RD_UP : FN_READ_BOTTOM, idx), 64'h0, 64'h0);
    endtask

    task automatic mul(input logic [31:0] x, y);
        p = $signed(x) * $signed(y);
        issue(sp(FN_SIGNED_WORD, 5'd0), ext(x), ext(y));
        lo = ext(p[31:0]);
        hi = ext(p[63:32]);
    endtask

    task automatic mac(input int gap);
        logic [15:0] r1, r2;
        r1 = 16'($random(seed));
        r2 = 16'($random(seed));
        p = $signed(r1) * $signed(r2);
        t = p + {hi[31:0], lo[31:0]};
        issue(sp(FN_HALFWORD_MAC, 5'd0), ext({{16{r1[15]}}, r1}), ext({{16{r2[15]}}, r2}));
        check(69'(st), 69'(gap));
        lo = ext(t[31:0]);
        hi = ext(t[63:32]);
    endtask

    // Oldest expected write-back against each one seen
    always @(negedge clk_sys_i) begin
        if (wb_valid_o === 1'b1) begin
            if (exp_q.size() == 0) e = '1;
            else e = exp_q.pop_front();
            check({wb_idx_o, wb_data_o}, e);
        end
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        {rstn_i, instr_valid_i, mode64_i, user_or_super_i, coproc_usable_i} = 5'h0;
        {dword_mul_issue_i, word_div_issue_i, dword_div_issue_i} = 3'h0;
        {instr_i, rs_val_i, rt_val_i, hi, lo} = '0;
        repeat (6) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        rd_prod(1'b0, 5'd3);
        for (int m = 0; m < 2; m++) begin
            mode64_i = m[0];
            // Two idle slots after a read before any product writer
            nop(2);
            v = ext(32'($random(seed)));
            issue(sp(FN_WRITE_BOTTOM, 5'd0), v, 64'h0);
            lo = v;
            nop(3);
            check(69'(bottom_defined_o), 69'(1));
            mul(32'h80000000, 32'h80000000);
            mac(1);
            mac(0);
            rd_prod(1'b0, 5'd4);
            rd_prod(1'b1, 5'd5);
            mac(2);
            nop(2);
            mul(32'($random(seed)), 32'($random(seed)));
            rd_prod(1'b1, 5'd6);
            rd_prod(1'b0, 5'd7);
            nop(3);
            for (int k = 0; k < 3; k++) begin
                dword_mul_issue_i = (k == 0);
                word_div_issue_i = (k == 1);
                dword_div_issue_i = (k == 2);
                @(posedge clk_sys_i);
                #1;
                {dword_mul_issue_i, word_div_issue_i, dword_div_issue_i} = 3'h0;
                mac(gaps[k]);
                rd_prod(1'b0, 5'(k));
                nop(3);
            end
            mul(32'($random(seed)), 32'($random(seed)));
            issue(sp(FN_WRITE_UPPER, 5'd0), 64'h5, 64'h0);
            nop(3);
            check(69'(upper_defined_o), 69'(0));
            rd_prod(1'b0, 5'd8);
            nop(2);
            v = ext(32'($random(seed)));
            issue(sp(FN_WRITE_UPPER, 5'd0), v, 64'h0);
            instr_valid_i = 1'b0;
            for (int c = 0; c < 3; c++) begin
                @(negedge clk_sys_i);
                check(69'(upper_defined_o), 69'(c == 2));
            end
            hi = v;
            @(posedge clk_sys_i);
            #1;
            rd_prod(1'b1, 5'd9);
            user_or_super_i = 1'b1;
            coproc_usable_i = 1'b1;
            v = ext(32'($random(seed)));
            issue(cp(SUB_MOVE_TO, 5'd9, 5'd12), 64'h0, v);
            check(69'({coproc_wr_en_o, coproc_unusable_o, coproc_wr_addr_o,
                       coproc_wr_data_o[31:0]}),
                  69'({1'b1, 1'b0, 5'd12, v[31:0]}));
            // No loads, stores or translation ops around the write
            nop(2);
            exp_q.push_back({5'd3, ext(v[31:0])});
            issue(cp(SUB_MOVE_FROM, 5'd3, 5'd12), 64'h0, 64'h0);
            exp_q.push_back({5'd4, ext(32'hc0de0001)});
            issue(cp(SUB_MOVE_FROM, 5'd4, 5'd1), 64'h0, 64'h0);
            coproc_usable_i = 1'b0;
            issue(cp(SUB_MOVE_TO, 5'd9, 5'd12), 64'h0, ~v);
            check(69'({coproc_unusable_o, coproc_wr_en_o}), 69'(2'b10));
            nop(2);
            issue(cp(SUB_MOVE_FROM, 5'd5, 5'd12), 64'h0, 64'h0);
            check(69'(coproc_unusable_o), 69'(1));
            nop(2);
            user_or_super_i = 1'b0;
            exp_q.push_back({5'd6, ext(v[31:0])});
            issue(cp(SUB_MOVE_FROM, 5'd6, 5'd12), 64'h0, 64'h0);
            rd_prod(1'b0, 5'd10);
        end
        nop(5);
        check(69'(exp_q.size()), 69'(0));
        give_verdict();
    end
endmodule

// ### src/mhu_hazard.sv
// Countdown of cycles during which a halfword accumulate must wait
`timescale 1ns/1ps
module mhu_hazard
    import mhu_pkg::*;
#(
    parameter int W = HZ_W
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rstn_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] gap_i,
    input  wire logic         mac_req_i,
    output logic              stall_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] dec;

    assign dec     = (cnt_r == '0) ? '0 : cnt_r - 1'b1;
    assign stall_o = mac_req_i && (cnt_r != '0);

    // Longest outstanding gap wins; a short one never cuts a long wait
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= (load_i && gap_i > dec) ? gap_i : dec;
        end
    end

    gap_load_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        load_i |=> cnt_r >= $past(gap_i))
        else $error("hazard gap not loaded");
endmodule

// ### src/mhu_mac.sv
// Signed word multiply and halfword multiply-accumulate, one register stage
`timescale 1ns/1ps
module mhu_mac
    import mhu_pkg::*;
(
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    mhu_mac_if.datapath m
);
    logic signed [31:0] half_p;
    logic signed [63:0] word_p;
    logic        [63:0] sum_nxt;

    assign half_p  = $signed(m.op_a[15:0]) * $signed(m.op_b[15:0]);
    assign word_p  = $signed(m.op_a[31:0]) * $signed(m.op_b[31:0]);
    // Plain wrapping add: no overflow trap exists on this path
    assign sum_nxt = {{32{half_p[31]}}, half_p} + m.acc;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            m.rsp_valid <= 1'b0;
            m.rsp_prod  <= PROD_RESET;
        end else begin
            m.rsp_valid <= m.req_valid;
            if (m.req_valid) begin
                m.rsp_prod <= m.req_mac ? sum_nxt : word_p;
            end
        end
    end

    half_mac_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        m.req_valid && m.req_mac |=> m.rsp_valid && (m.rsp_prod ==
            $past({{48{m.op_a[15]}}, m.op_a[15:0]} * {{48{m.op_b[15]}}, m.op_b[15:0]}
                  + m.acc)))
        else $error("halfword accumulate result wrong");
    word_mul_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        m.req_valid && !m.req_mac |=> m.rsp_prod ==
            $past({{32{m.op_a[31]}}, m.op_a[31:0]} * {{32{m.op_b[31]}}, m.op_b[31:0]}))
        else $error("signed word product wrong");
endmodule

// ### src/mhu_mac_if.sv
// Request/answer path between issue logic and the product datapath
`timescale 1ns/1ps
interface mhu_mac_if;
    logic        req_valid;
    logic        req_mac;
    logic [63:0] op_a;
    logic [63:0] op_b;
    logic [63:0] acc;
    logic        rsp_valid;
    logic [63:0] rsp_prod;
    modport issue    (output req_valid, req_mac, op_a, op_b, acc, input rsp_valid, rsp_prod);
    modport datapath (input req_valid, req_mac, op_a, op_b, acc, output rsp_valid, rsp_prod);
endinterface

// ### src/mhu_pkg.sv
// Shared constants, types and helpers of the multiply/accumulate unit
package mhu_pkg;
    localparam logic [5:0] OPC_SPECIAL     = 6'h00;
    localparam logic [5:0] OPC_SYS_COPROC  = 6'h10;
    localparam logic [4:0] SUB_MOVE_FROM   = 5'h00;
    localparam logic [4:0] SUB_MOVE_TO     = 5'h04;
    localparam logic [5:0] FN_READ_BOTTOM  = 6'h12;
    localparam logic [5:0] FN_WRITE_UPPER  = 6'h11;
    localparam logic [5:0] FN_WRITE_BOTTOM = 6'h13;
    localparam logic [5:0] FN_SIGNED_WORD  = 6'h18;
    localparam logic [5:0] FN_HALFWORD_MAC = 6'h28;
    localparam int         HZ_W            = 7;
    localparam logic [HZ_W-1:0] GAP_WORD_MUL  = 7'h01;
    localparam logic [HZ_W-1:0] GAP_DWORD_MUL = 7'h04;
    localparam logic [HZ_W-1:0] GAP_WORD_DIV  = 7'h24;
    localparam logic [HZ_W-1:0] GAP_DWORD_DIV = 7'h44;
    localparam logic [HZ_W-1:0] GAP_PROD_READ = 7'h02;
    localparam logic [HZ_W-1:0] GAP_NONE      = 7'h00;
    localparam logic [63:0]     PROD_RESET    = 64'h0;

    typedef enum logic [3:0] {
        OP_NONE      = 4'b0000,
        OP_RD_UPPER  = 4'b0001,
        OP_RD_BOTTOM = 4'b0010,
        OP_WR_UPPER  = 4'b0011,
        OP_WR_BOTTOM = 4'b0100,
        OP_MUL_WORD  = 4'b0101,
        OP_MAC_HALF  = 4'b0110,
        OP_RD_COPROC = 4'b0111,
        OP_WR_COPROC = 4'b1000
    } mhu_op_t;

    // Word into a product or general register: sign-extended in 64-bit mode
    function automatic logic [63:0] mhu_word(input logic [31:0] w, input logic m64);
        mhu_word = m64 ? {{32{w[31]}}, w} : {32'h0, w};
    endfunction

    function automatic mhu_op_t mhu_decode(input logic [31:0] ins,
                                           input logic [5:0]  fn_rd_upper);
        mhu_decode = OP_NONE;
        if (ins[31:26] == OPC_SYS_COPROC) begin
            if (ins[25:21] == SUB_MOVE_FROM) mhu_decode = OP_RD_COPROC;
            if (ins[25:21] == SUB_MOVE_TO)   mhu_decode = OP_WR_COPROC;
        end else if (ins[31:26] == OPC_SPECIAL) begin
            if (ins[5:0] == fn_rd_upper)     mhu_decode = OP_RD_UPPER;
            if (ins[5:0] == FN_READ_BOTTOM)  mhu_decode = OP_RD_BOTTOM;
            if (ins[5:0] == FN_WRITE_UPPER)  mhu_decode = OP_WR_UPPER;
            if (ins[5:0] == FN_WRITE_BOTTOM) mhu_decode = OP_WR_BOTTOM;
            if (ins[5:0] == FN_SIGNED_WORD)  mhu_decode = OP_MUL_WORD;
            if (ins[5:0] == FN_HALFWORD_MAC) mhu_decode = OP_MAC_HALF;
        end
    endfunction
endpackage

// ### src/mhu_unit.sv
// Product register pair, multiply issue and system coprocessor moves
`timescale 1ns/1ps
// Functional notes
// - Halfword accumulate multiplies signed 16-bit operands
// - Product added to upper:bottom 64-bit pair
// - Multiplies never raise an overflow exception
// - Low word to bottom, high to upper
// - Accumulate waits 4/36/68 after dword mul/divides
// - Accumulate waits 1 after mul, 2 after read
// - Coprocessor read: fetch at T, write T+2
// - Coprocessor write: take at T, store T+1
// - Coprocessor moves trap when unusable in user/supervisor
// - Read bottom copies it in one cycle
// - Write upper; undefined two cycles before commit
// - Write bottom; undefined two cycles before commit
// - Write right after multiply leaves register undefined
// - Word multiply treats operands as signed 32-bit
module mhu_unit
    import mhu_pkg::*;
#(
    parameter logic [5:0] FN_READ_UPPER = 6'h10
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        instr_valid_i,
    input  wire logic [31:0] instr_i,
    input  wire logic [63:0] rs_val_i,
    input  wire logic [63:0] rt_val_i,
    input  wire logic        mode64_i,
    input  wire logic        user_or_super_i,
    input  wire logic        coproc_usable_i,
    input  wire logic        dword_mul_issue_i,
    input  wire logic        word_div_issue_i,
    input  wire logic        dword_div_issue_i,
    input  wire logic [31:0] coproc_rd_data_i,
    output logic             stall_o,
    output logic             wb_valid_o,
    output logic [4:0]       wb_idx_o,
    output logic [63:0]      wb_data_o,
    output logic [4:0]       coproc_rd_addr_o,
    output logic             coproc_wr_en_o,
    output logic [4:0]       coproc_wr_addr_o,
    output logic [63:0]      coproc_wr_data_o,
    output logic             coproc_unusable_o,
    output logic             upper_defined_o,
    output logic             bottom_defined_o
);
    mhu_mac_if mac_bus ();

    mhu_op_t         op;
    logic            acc_ok;
    logic            cop_op;
    logic            cop_trap;
    logic            hz_stall;
    logic            hz_load;
    logic [HZ_W-1:0] hz_gap;
    logic [63:0]     upper_r;
    logic [63:0]     bottom_r;
    logic [63:0]     upper_fwd;
    logic [63:0]     bottom_fwd;
    logic            crd_pend_r;
    logic [4:0]      crd_idx_r;
    logic [63:0]     crd_data_r;
    logic [2:1]      wu_stage_r;
    logic [2:1]      wb_stage_r;
    logic [63:0]     wu_data_r [1:2];
    logic [63:0]     wbt_data_r [1:2];
    logic            mul_since_r;
    logic            upper_ok_r;
    logic            bottom_ok_r;
    logic            mul_done;
    logic [2:1]      wr_dirty_r;

    assign op       = mhu_decode(instr_i, FN_READ_UPPER);
    assign cop_op   = (op == OP_RD_COPROC) || (op == OP_WR_COPROC);
    // A coprocessor writeback in flight owns the writeback port next cycle
    assign stall_o  = instr_valid_i && (hz_stall || (crd_pend_r &&
                      (op == OP_RD_UPPER || op == OP_RD_BOTTOM || op == OP_RD_COPROC)));
    assign acc_ok   = instr_valid_i && !stall_o;
    assign cop_trap = cop_op && user_or_super_i && !coproc_usable_i;
    assign mul_done = mac_bus.rsp_valid;

    // Back-to-back accumulates see the previous result before it lands
    assign upper_fwd  = mul_done ? mhu_word(mac_bus.rsp_prod[63:32], mode64_i) : upper_r;
    assign bottom_fwd = mul_done ? mhu_word(mac_bus.rsp_prod[31:0], mode64_i) : bottom_r;

    assign mac_bus.req_valid = acc_ok && (op == OP_MUL_WORD || op == OP_MAC_HALF);
    assign mac_bus.req_mac   = (op == OP_MAC_HALF);
    assign mac_bus.op_a      = rs_val_i;
    assign mac_bus.op_b      = rt_val_i;
    assign mac_bus.acc       = {upper_fwd[31:0], bottom_fwd[31:0]};

    mhu_mac u_mac (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .m         (mac_bus)
    );

    // Largest gap demanded by this cycle's events
    always_comb begin
        hz_gap = GAP_NONE;
        if (acc_ok && op == OP_MUL_WORD)                          hz_gap = GAP_WORD_MUL;
        if (acc_ok && (op == OP_RD_UPPER || op == OP_RD_BOTTOM))  hz_gap = GAP_PROD_READ;
        if (dword_mul_issue_i)                                    hz_gap = GAP_DWORD_MUL;
        if (word_div_issue_i)                                     hz_gap = GAP_WORD_DIV;
        if (dword_div_issue_i)                                    hz_gap = GAP_DWORD_DIV;
    end
    assign hz_load = (hz_gap != GAP_NONE);

    mhu_hazard #(.W(HZ_W)) u_hazard (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .load_i    (hz_load),
        .gap_i     (hz_gap),
        .mac_req_i (instr_valid_i && op == OP_MAC_HALF),
        .stall_o   (hz_stall)
    );

    // Product writes land two cycles after issue
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wu_stage_r <= '0;
            wb_stage_r <= '0;
            wu_data_r  <= '{default: PROD_RESET};
            wbt_data_r <= '{default: PROD_RESET};
            wr_dirty_r <= '0;
        end else begin
            wu_stage_r <= {wu_stage_r[1], acc_ok && op == OP_WR_UPPER};
            wb_stage_r <= {wb_stage_r[1], acc_ok && op == OP_WR_BOTTOM};
            wu_data_r[1] <= rs_val_i;
            wu_data_r[2] <= wu_data_r[1];
            wbt_data_r[1] <= rs_val_i;
            wbt_data_r[2] <= wbt_data_r[1];
            // History taken at accept: the write itself clears it at that same edge
            wr_dirty_r <= {wr_dirty_r[1], mul_since_r};
        end
    end

    // Multiply result wins over a stale register write landing alongside
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            upper_r  <= PROD_RESET;
            bottom_r <= PROD_RESET;
        end else if (mul_done) begin
            upper_r  <= upper_fwd;
            bottom_r <= bottom_fwd;
        end else begin
            if (wu_stage_r[2]) upper_r  <= wu_data_r[2];
            if (wb_stage_r[2]) bottom_r <= wbt_data_r[2];
        end
    end

    // Validity of each product register as seen by the pipeline
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mul_since_r <= 1'b0;
            upper_ok_r  <= 1'b1;
            bottom_ok_r <= 1'b1;
        end else begin
            if (mac_bus.req_valid || dword_mul_issue_i || word_div_issue_i ||
                dword_div_issue_i) begin
                mul_since_r <= 1'b1;
            end else if (acc_ok && (op == OP_RD_UPPER || op == OP_RD_BOTTOM ||
                                    op == OP_WR_UPPER || op == OP_WR_BOTTOM)) begin
                mul_since_r <= 1'b0;
            end
            if (mul_done) begin
                upper_ok_r  <= 1'b1;
                bottom_ok_r <= 1'b1;
            end else begin
                if (wu_stage_r[2]) upper_ok_r <= !wr_dirty_r[2];
                if (wb_stage_r[2]) bottom_ok_r <= !wr_dirty_r[2];
            end
            // A write taken now stays undefined even beside a landing product
            if (acc_ok && op == OP_WR_UPPER) upper_ok_r <= 1'b0;
            if (acc_ok && op == OP_WR_BOTTOM) bottom_ok_r <= 1'b0;
        end
    end
    assign upper_defined_o  = upper_ok_r;
    assign bottom_defined_o = bottom_ok_r;

    // System coprocessor moves
    assign coproc_rd_addr_o = instr_i[15:11];

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crd_pend_r        <= 1'b0;
            crd_idx_r         <= 5'h0;
            crd_data_r        <= PROD_RESET;
            coproc_wr_en_o    <= 1'b0;
            coproc_wr_addr_o  <= 5'h0;
            coproc_wr_data_o  <= PROD_RESET;
            coproc_unusable_o <= 1'b0;
        end else begin
            crd_pend_r        <= acc_ok && op == OP_RD_COPROC && !cop_trap;
            coproc_wr_en_o    <= acc_ok && op == OP_WR_COPROC && !cop_trap;
            coproc_unusable_o <= acc_ok && cop_trap;
            if (acc_ok && op == OP_RD_COPROC) begin
                crd_idx_r  <= instr_i[20:16];
                crd_data_r <= mhu_word(coproc_rd_data_i, mode64_i);
            end
            if (acc_ok && op == OP_WR_COPROC) begin
                coproc_wr_addr_o <= instr_i[15:11];
                coproc_wr_data_o <= rt_val_i;
            end
        end
    end

    // General register writeback
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wb_valid_o <= 1'b0;
            wb_idx_o   <= 5'h0;
            wb_data_o  <= PROD_RESET;
        end else begin
            wb_valid_o <= 1'b0;
            if (crd_pend_r) begin
                wb_valid_o <= 1'b1;
                wb_idx_o   <= crd_idx_r;
                wb_data_o  <= crd_data_r;
            end else if (acc_ok && op == OP_RD_BOTTOM) begin
                wb_valid_o <= 1'b1;
                wb_idx_o   <= instr_i[15:11];
                wb_data_o  <= bottom_fwd;
            end else if (acc_ok && op == OP_RD_UPPER) begin
                wb_valid_o <= 1'b1;
                wb_idx_o   <= instr_i[15:11];
                wb_data_o  <= upper_fwd;
            end
        end
    end

    // Multiply results and accumulate issue gaps
    prod_split_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        mul_done |=> bottom_r == $past(mhu_word(mac_bus.rsp_prod[31:0], mode64_i)) &&
                     upper_r == $past(mhu_word(mac_bus.rsp_prod[63:32], mode64_i)))
        else $error("product words misplaced");
    no_ovf_trap_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        mac_bus.req_valid |=> !coproc_unusable_o)
        else $error("multiply raised a trap");
    dmul_gap_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        dword_mul_issue_i |=> !(acc_ok && op == OP_MAC_HALF) [*4])
        else $error("accumulate issued inside dword multiply gap");
    div_gap_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        word_div_issue_i || dword_div_issue_i |=> !(acc_ok && op == OP_MAC_HALF) [*8])
        else $error("accumulate issued inside divide gap");
    read_gap_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && (op == OP_RD_UPPER || op == OP_RD_BOTTOM)
        |=> !(acc_ok && op == OP_MAC_HALF) [*2])
        else $error("accumulate issued too soon after product read");
    mac_stall_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && op == OP_MUL_WORD ##1 instr_valid_i && op == OP_MAC_HALF |-> stall_o)
        else $error("accumulate not held after word multiply");

    // Coprocessor moves
    cop_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && op == OP_RD_COPROC && !cop_trap |-> ##2 wb_valid_o &&
            wb_idx_o == $past(instr_i[20:16], 2) &&
            wb_data_o == $past(mhu_word(coproc_rd_data_i, mode64_i), 2))
        else $error("coprocessor read writeback wrong");
    cop_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && op == OP_WR_COPROC && !cop_trap
        |=> coproc_wr_en_o && coproc_wr_data_o == $past(rt_val_i) &&
            coproc_wr_addr_o == $past(instr_i[15:11]))
        else $error("coprocessor write not stored next cycle");
    cop_trap_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && cop_trap |=> coproc_unusable_o && !coproc_wr_en_o && !crd_pend_r)
        else $error("unusable coprocessor move not trapped");
    cop_kernel_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && cop_op && !user_or_super_i |=> !coproc_unusable_o)
        else $error("coprocessor move trapped in kernel mode");
    cop_wb_port_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        crd_pend_r |-> !(acc_ok && (op == OP_RD_UPPER || op == OP_RD_BOTTOM)))
        else $error("product read taken over coprocessor writeback");

    // Product register reads and writes
    rd_bottom_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && op == OP_RD_BOTTOM |=> wb_valid_o && wb_data_o == $past(bottom_fwd) &&
            wb_idx_o == $past(instr_i[15:11]))
        else $error("bottom read wrong");
    wr_upper_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && op == OP_WR_UPPER && !mac_bus.rsp_valid ##1 !mac_bus.rsp_valid [*2]
        |-> !upper_defined_o ##1 upper_r == $past(rs_val_i, 3))
        else $error("upper write timing wrong");
    wr_bottom_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && op == OP_WR_BOTTOM |=> !bottom_defined_o [*2])
        else $error("bottom not undefined during write");
    wr_after_mul_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        mul_since_r && acc_ok && op == OP_WR_UPPER && !mac_bus.req_valid
        ##1 !mac_bus.rsp_valid [*2] |=> !upper_defined_o)
        else $error("write after multiply shown as defined");
    wr_bot_mul_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        mul_since_r && acc_ok && op == OP_WR_BOTTOM
        ##1 !mac_bus.rsp_valid [*2] |=> !bottom_defined_o)
        else $error("bottom write after multiply shown as defined");
    read_clears_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        acc_ok && (op == OP_RD_UPPER || op == OP_RD_BOTTOM) &&
        !(dword_mul_issue_i || word_div_issue_i || dword_div_issue_i) |=> !mul_since_r)
        else $error("product read did not clear multiply history");
endmodule
